// >>> hw/ecp_mode_regs.svh
// Register offsets, field positions, encodings and timing counts for the
// parallel port mode control. Assumes byte-wide register port, 11-bit address.
`ifndef ECP_MODE_REGS_SVH
`define ECP_MODE_REGS_SVH

// Register offsets
`define OFF_DATA 11'h000
`define OFF_STATUS 11'h001
`define OFF_CTRL 11'h002
`define OFF_QUEUE 11'h400
`define OFF_CFG_B 11'h401
`define OFF_EXT_CTRL 11'h402
`define OFF_OPTION 11'h403

// Mode field codes
`define MODE_STD 3'h0
`define MODE_BIDIR 3'h1
`define MODE_FIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7

// Field positions
`define EXT_MODE_HI 7
`define EXT_MODE_LO 5
`define EXT_FULL 1
`define EXT_EMPTY 0
`define CTRL_STROBE 0
`define CTRL_AUTOFD 1
`define CTRL_INIT 2
`define CTRL_SELIN 3
`define CTRL_DIR 5
`define OPT_EPP 0

// Reset and fixed values
`define CFG_A_VALUE 8'h10
`define CTRL_RESET 6'h00
`define EXT_RESET 8'h00
`define ZERO_BYTE 8'h00

// Handshake timing: forward strobe setup, in ns and cycles at 50 MHz
`define CLK_NS 20
`define HS_SETUP_NS 500
`define HS_SETUP_CYC ((`HS_SETUP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> hw/ecp_mode_pkg.sv
// Types shared by the parallel port mode control.
// Assumes the mode codes named in ecp_mode_regs.svh.
package ecp_mode_pkg;
	// Handshake engine states, one-hot
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_SETUP = 4'h2,
		HS_WAIT = 4'h4,
		HS_DONE = 4'h8
	} hs_state_t;
endpackage : ecp_mode_pkg

// >>> hw/ecp_mode_ctrl.sv
// Mode control, FIFO and automatic handshake of an extended parallel port.
// Assumes one 50 MHz clock, synchronous reset, pins from outside the domain.
// What this block does
// RULE1 - Empty bit reads 1 when FIFO holds nothing
// RULE2 - Standard mode: FIFO reset, open-drain, no tristate
// RULE3 - Bidirectional mode: direction tristates, live data read
// RULE4 - FIFO mode sends bytes with standard handshake
// RULE5 - ECP forward merges data and command writes
// RULE6 - ECP reverse fills FIFO from peripheral
// RULE7 - EPP mode only if option enabled
// RULE8 - Test mode FIFO access, nothing sent
// RULE9 - Config mode maps bytes A and B
// RULE10 - Byte B bits 5:3 encode interrupt line
// RULE11 - Byte B bits 2:0 encode DMA channel
// RULE12 - Modes 011/010 start automatic handshake
// RULE13 - Extended modes may only return to 000/001
// RULE14 - Direction changes only in mode 001
// RULE15 - Handshake outputs deasserted before leaving mode; the code drops them one cycle after mode_r changes
// RULE16 - Leaving reverse drops autofeed, discards bytes
// RULE17 - Glitch-free handshake outputs on mode change
// RULE18 - Host sets direction, strobe, autofeed before ECP
// RULE19 - Single bytes; commands tagged, forward only
// RULE20 - Host reverses channel through mode 001
// RULE21 - Reverse keeps filling FIFO, host reads anytime
// RULE22 - Host terminates ECP only in forward direction
// RULE23 - Mode held in extended control bits 7:5
// RULE24 - Direction 0 output, 1 input outside 000/010
`timescale 1ns/1ns
`include "ecp_mode_regs.svh"

module ecp_mode_ctrl #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter logic [3:0] IRQ_LINE = 4'h7,
	parameter logic [2:0] DMA_CHAN = 3'h3,
	parameter logic [7:0] SETUP_CYC = 8'(`HS_SETUP_CYC)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [10:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Data lines, three signals
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic pd_oe_n,
	// Control outputs, low-active pins and the active-high open-drain enable
	output logic strobe_n_out,
	output logic autofd_n_out,
	output logic init_n_out,
	output logic selin_n_out,
	output logic ctrl_open_drain,
	// Peripheral status inputs
	input wire logic busy_in,
	input wire logic ack_n_in,
	input wire logic fault_n_in,
	input wire logic select_in,
	input wire logic perror_in,
	// Mode indication
	output logic epp_active
);

	// Pin synchronisers, two stages
	logic [12:0] sync1_r, sync2_r;
	logic [7:0] pd_s;
	logic busy_s, ack_n_s, fault_n_s, select_s, perror_s;
	assign {pd_s, busy_s, ack_n_s, fault_n_s, select_s, perror_s} = sync2_r;

	// Register state
	logic [5:0] ctrl_r, ctrl_nxt; // Device control bits
	logic [2:0] mode_r, mode_nxt; // Mode field
	logic [2:0] ext_lo_r, ext_lo_nxt; // Other read/write ecr bits 4:2
	logic [7:0] data_r, data_nxt; // Latched data register
	logic opt_r, opt_nxt; // Chip option: EPP supported
	logic [7:0] rdata_r, rdata_nxt; // Read data
	// FIFO storage and pointers
	logic [8:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop, fifo_clr;
	logic [8:0] push_word;
	// Handshake engine
	ecp_mode_pkg::hs_state_t hs_r, hs_nxt;
	logic [7:0] tmr_r, tmr_nxt;
	logic [7:0] out_r, out_nxt; // Byte on the data lines
	logic hs_strobe_r, hs_strobe_nxt; // Forward strobe, active high
	logic hs_afd_r, hs_afd_nxt; // Autofeed / host-ack, active high

	// Decoded state
	logic empty, full, dir, fwd_auto, rev_auto, auto_mode;
	logic [2:0] irq_code, dma_code;
	assign empty = (cnt_r == '0); // RULE1
	assign full = (cnt_r == (AW+1)'(DEPTH));
	assign dir = ctrl_r[`CTRL_DIR];
	assign fwd_auto = (mode_r == `MODE_FIFO) ||
		(mode_r == `MODE_ECP && !dir); // RULE4 RULE5 RULE12
	assign rev_auto = (mode_r == `MODE_ECP) && dir; // RULE6 RULE12
	assign auto_mode = fwd_auto || rev_auto;
	assign epp_active = (mode_r == `MODE_EPP) && opt_r; // RULE7

	// Interrupt line code
	always_comb begin
		case (IRQ_LINE) // RULE10
			4'hF: irq_code = 3'h6;
			4'hE: irq_code = 3'h5;
			4'hB: irq_code = 3'h4;
			4'hA: irq_code = 3'h3;
			4'h9: irq_code = 3'h2;
			4'h7: irq_code = 3'h1;
			4'h5: irq_code = 3'h7;
			default: irq_code = 3'h0;
		endcase
	end

	// DMA channel code
	always_comb begin
		case (DMA_CHAN) // RULE11
			3'h1, 3'h2, 3'h3: dma_code = DMA_CHAN;
			default: dma_code = 3'h0;
		endcase
	end

	// Register writes, reads and FIFO host side
	always_comb begin
		logic [2:0] req;
		req = reg_wdata[`EXT_MODE_HI:`EXT_MODE_LO];
		ctrl_nxt = ctrl_r;
		mode_nxt = mode_r;
		ext_lo_nxt = ext_lo_r;
		data_nxt = data_r;
		opt_nxt = opt_r;
		rdata_nxt = `ZERO_BYTE;
		push = 1'b0;
		push_word = {1'b0, reg_wdata};
		pop = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				`OFF_DATA: begin
					if (mode_r == `MODE_ECP) begin
						// Command bytes only go forward
						push = !dir && !full; // RULE19 RULE5
						push_word = {1'b1, reg_wdata}; // RULE19
					end else begin
						data_nxt = reg_wdata;
					end
				end
				`OFF_CTRL: begin
					ctrl_nxt[4:0] = reg_wdata[4:0];
					if (mode_r == `MODE_BIDIR) begin
						ctrl_nxt[`CTRL_DIR] = reg_wdata[`CTRL_DIR]; // RULE14
					end
				end
				`OFF_QUEUE: begin
					// Data port in FIFO, ECP forward and test modes
					if ((mode_r == `MODE_FIFO || mode_r == `MODE_TEST ||
						(mode_r == `MODE_ECP && !dir)) && !full) begin
						push = 1'b1; // RULE4 RULE5 RULE8
					end
				end
				`OFF_EXT_CTRL: begin
					ext_lo_nxt = reg_wdata[4:2];
					// Extended modes may only drop back to 000/001
					if (mode_r == `MODE_STD || mode_r == `MODE_BIDIR ||
						req == `MODE_STD || req == `MODE_BIDIR) begin
						mode_nxt = req; // RULE13 RULE23
					end
				end
				`OFF_OPTION: opt_nxt = reg_wdata[`OPT_EPP];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`OFF_DATA: begin
					// Bidirectional mode reads the live lines
					rdata_nxt = (mode_r == `MODE_STD) ? data_r : pd_s; // RULE3
				end
				`OFF_STATUS: rdata_nxt = {!busy_s, ack_n_s, perror_s,
					select_s, fault_n_s, 3'h0};
				`OFF_CTRL: rdata_nxt = {2'h0, ctrl_r};
				`OFF_QUEUE: begin
					if (mode_r == `MODE_CFG) begin
						rdata_nxt = `CFG_A_VALUE; // RULE9
					end else if (mode_r == `MODE_TEST ||
						(mode_r == `MODE_ECP && dir)) begin
						rdata_nxt = mem_r[rp_r][7:0]; // RULE8 RULE21
						pop = !empty;
					end
				end
				`OFF_CFG_B: begin
					if (mode_r == `MODE_CFG) begin
						rdata_nxt = {1'b0, 1'b0, irq_code, dma_code}; // RULE9
					end
				end
				`OFF_EXT_CTRL: rdata_nxt = {mode_r, ext_lo_r, full, empty};
				`OFF_OPTION: rdata_nxt = {7'h0, opt_r};
				default: ;
			endcase
		end
	end

	// Handshake engine: forward strobe/busy and reverse autofd/ack
	always_comb begin
		hs_nxt = hs_r;
		tmr_nxt = tmr_r;
		out_nxt = out_r;
		hs_strobe_nxt = 1'b0;
		hs_afd_nxt = 1'b0;
		case (hs_r)
			ecp_mode_pkg::HS_IDLE: begin
				if (fwd_auto && !empty && !busy_s) begin
					out_nxt = mem_r[rp_r][7:0];
					hs_afd_nxt = (mode_r == `MODE_ECP) && mem_r[rp_r][8];
					tmr_nxt = SETUP_CYC;
					hs_nxt = ecp_mode_pkg::HS_SETUP; // RULE12
				end else if (rev_auto && !full && ack_n_s) begin
					// Next request only once the peripheral released ack
					hs_afd_nxt = 1'b1; // Ask peripheral for a byte
					hs_nxt = ecp_mode_pkg::HS_WAIT; // RULE6 RULE21
				end
			end
			ecp_mode_pkg::HS_SETUP: begin
				hs_afd_nxt = hs_afd_r;
				hs_strobe_nxt = (tmr_r != 8'h0);
				tmr_nxt = tmr_r - 8'h1;
				if (tmr_r == 8'h0) begin
					hs_nxt = ecp_mode_pkg::HS_DONE;
				end
			end
			ecp_mode_pkg::HS_WAIT: begin
				hs_afd_nxt = 1'b1;
				if (!ack_n_s) begin
					hs_afd_nxt = 1'b0;
					hs_nxt = ecp_mode_pkg::HS_DONE;
				end
			end
			ecp_mode_pkg::HS_DONE: begin
				hs_nxt = ecp_mode_pkg::HS_IDLE;
			end
			default: hs_nxt = ecp_mode_pkg::HS_IDLE;
		endcase
		// Leaving automatic mode drops every handshake output one cycle after mode_r changes
		if (!auto_mode) begin
			hs_nxt = ecp_mode_pkg::HS_IDLE; // RULE15 RULE16
			hs_strobe_nxt = 1'b0; // RULE15
			hs_afd_nxt = 1'b0; // RULE16
		end
	end

	// FIFO pointer and count next values
	always_comb begin
		logic hw_pop, hw_push;
		hw_pop = (hs_r == ecp_mode_pkg::HS_SETUP) && (tmr_r == 8'h0);
		hw_push = (hs_r == ecp_mode_pkg::HS_WAIT) && !ack_n_s &&
			rev_auto && !full;
		// Standard mode holds the FIFO empty; stale reverse bytes dropped
		fifo_clr = (mode_r == `MODE_STD) || (mode_r == `MODE_BIDIR); // RULE2 RULE16
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (fifo_clr) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push || hw_push) begin
				wp_nxt = wp_r + AW'(1);
			end
			if (pop || hw_pop) begin
				rp_nxt = rp_r + AW'(1);
			end
			cnt_nxt = cnt_r + (AW+1)'(push || hw_push) -
				(AW+1)'(pop || hw_pop);
		end
	end

	// Pin outputs decoded by gates from flip-flops only, no input paths
	always_comb begin
		pd_out = auto_mode ? out_r : data_r;
		// Only 000 and 010 force output; every other mode honours direction
		pd_oe_n = (mode_r == `MODE_STD || mode_r == `MODE_FIFO) ?
			1'b0 : dir; // RULE2 RULE3 RULE24
		strobe_n_out = !(ctrl_r[`CTRL_STROBE] || hs_strobe_r); // RULE17
		autofd_n_out = !(ctrl_r[`CTRL_AUTOFD] || hs_afd_r); // RULE17
		init_n_out = ctrl_r[`CTRL_INIT];
		selin_n_out = !ctrl_r[`CTRL_SELIN];
		ctrl_open_drain = (mode_r == `MODE_STD); // RULE2
		reg_rdata = rdata_r;
	end

	// Register all state
	always_ff @(posedge clk_sys) begin
		sync1_r <= {pd_in, busy_in, ack_n_in, fault_n_in, select_in, perror_in};
		sync2_r <= sync1_r;
		if (sys_rst) begin
			ctrl_r <= `CTRL_RESET;
			mode_r <= `MODE_STD;
			ext_lo_r <= 3'h0;
			data_r <= `ZERO_BYTE;
			opt_r <= 1'b0;
			rdata_r <= `ZERO_BYTE;
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			hs_r <= ecp_mode_pkg::HS_IDLE;
			tmr_r <= 8'h0;
			out_r <= `ZERO_BYTE;
			hs_strobe_r <= 1'b0;
			hs_afd_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			mode_r <= mode_nxt;
			ext_lo_r <= ext_lo_nxt;
			data_r <= data_nxt;
			opt_r <= opt_nxt;
			rdata_r <= rdata_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			hs_r <= hs_nxt;
			tmr_r <= tmr_nxt;
			out_r <= out_nxt;
			hs_strobe_r <= hs_strobe_nxt;
			hs_afd_r <= hs_afd_nxt;
		end
	end

	// FIFO storage write, reverse bytes from the lines
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wp_r] <= push_word;
		end else if (hs_r == ecp_mode_pkg::HS_WAIT && !ack_n_s && !full) begin
			mem_r[wp_r] <= {1'b0, pd_s}; // RULE6
		end
	end

	// Checks
	empty_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && reg_addr == `OFF_EXT_CTRL) |=>
		reg_rdata[`EXT_EMPTY] == $past(empty)) // RULE1
		else $error("empty bit wrong");
	std_fifo_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_r == `MODE_STD) |-> ctrl_open_drain ##1 cnt_r == '0) // RULE2
		else $error("fifo not held in standard mode");
	std_no_tristate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_r == `MODE_STD || mode_r == `MODE_FIFO) |-> !pd_oe_n) // RULE2
		else $error("data lines released");
	mode_switch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		($changed(mode_r) && $past(mode_r) > `MODE_BIDIR) |->
		mode_r <= `MODE_BIDIR) // RULE13
		else $error("illegal mode switch");
	dir_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		($past(mode_r) != `MODE_BIDIR) |-> $stable(dir)) // RULE14
		else $error("direction changed outside 001");
	hs_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!auto_mode |=> !hs_strobe_r && !hs_afd_r) // RULE15
		else $error("handshake not deasserted");
	cfg_b_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && reg_addr == `OFF_CFG_B && mode_r == `MODE_CFG) |=>
		reg_rdata[5:0] == {irq_code, dma_code}) // RULE10
		else $error("config byte B wrong");
	epp_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		epp_active |-> opt_r && mode_r == `MODE_EPP) // RULE7
		else $error("epp without option");
	cmd_fwd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_wr && reg_addr == `OFF_DATA && mode_r == `MODE_ECP && dir)
		|=> cnt_r <= $past(cnt_r)) // RULE19
		else $error("command accepted in reverse");

endmodule : ecp_mode_ctrl

// >>> tb/ecp_periph_model.sv
// Peripheral model on the far side of the parallel port.
// Assumes the host drives strobe and autofeed at 50 MHz.
`timescale 1ns/1ns
module ecp_periph_model #(
	parameter int STALL = 3
) (
	// Clock
	input wire logic clk_sys,
	// Host side pins
	input wire logic [7:0] pd_out,
	input wire logic pd_oe_n,
	input wire logic strobe_n_out,
	input wire logic autofd_n_out,
	// Peripheral pins
	output logic [7:0] pd_in,
	output logic busy_in,
	output logic ack_n_in,
	// Capture report
	output logic got_v,
	output logic [8:0] got_byte
);
	logic stb_q; // Strobe seen last cycle
	logic [7:0] nxt_r; // Next reverse byte
	int cnt; // Busy or pause countdown
	initial begin
		stb_q = 1'h1;
		nxt_r = 8'hA0;
		ack_n_in = 1'h1;
		got_v = 1'h0;
		got_byte = 9'h000;
		cnt = 0;
	end
	// Capture on strobe fall, reverse handshake on autofeed
	always @(posedge clk_sys) begin
		got_v <= 1'h0;
		stb_q <= strobe_n_out;
		if (cnt != 0)
			cnt <= cnt - 1;
		if (stb_q && !strobe_n_out) begin
			got_v <= 1'h1;
			got_byte <= {~autofd_n_out, pd_out};
			cnt <= STALL;
		end
		if (!autofd_n_out && ack_n_in && cnt == 0 && pd_oe_n)
			ack_n_in <= 1'h0;
		if (!ack_n_in && autofd_n_out) begin
			ack_n_in <= 1'h1;
			nxt_r <= nxt_r + 8'h01;
			cnt <= STALL;
		end
	end
	// Busy while stalling; data inverted when not valid
	assign busy_in = cnt != 0;
	assign pd_in = pd_oe_n ? (ack_n_in ? ~nxt_r : nxt_r) : pd_out;
endmodule : ecp_periph_model

// >>> tb/ecp_mode_ctrl_tb.sv
// Self-checking bench of the parallel port mode control.
// Assumes design under hw/ and the peripheral model beside it.
`timescale 1ns/1ns
module ecp_mode_ctrl_tb;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [10:0] reg_addr = 11'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic rd_chk = 1'h0; // Read result is to be compared
	logic chk_q = 1'h0;
	logic [7:0] reg_rdata, pd_in, pd_out, v;
	logic pd_oe_n, strobe_n_out, autofd_n_out, ctrl_open_drain;
	logic busy_in, ack_n_in, epp_active, got_v;
	logic init_n_out, selin_n_out;
	logic fault_n_in = 1'h1; // Status pin levels, random
	logic select_in = 1'h1;
	logic perror_in = 1'h0;
	logic [8:0] got_byte;
	logic [7:0] rq[$]; // Expected read data
	logic [8:0] pq[$]; // Expected peripheral bytes
	logic [7:0] d[5];
	int n_errors = 0;
	int tests_run = 0;

	always #10 clk_sys = ~clk_sys;

	ecp_mode_ctrl #(.DEPTH(4), .AW(2), .IRQ_LINE(4'hE), .DMA_CHAN(3'h2),
		.SETUP_CYC(8'h02)) DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pd_in(pd_in), .pd_out(pd_out),
		.pd_oe_n(pd_oe_n), .strobe_n_out(strobe_n_out),
		.autofd_n_out(autofd_n_out), .init_n_out(init_n_out),
		.selin_n_out(selin_n_out),
		.ctrl_open_drain(ctrl_open_drain), .busy_in(busy_in),
		.ack_n_in(ack_n_in), .fault_n_in(fault_n_in), .select_in(select_in),
		.perror_in(perror_in), .epp_active(epp_active));

	ecp_periph_model PERIPH (.clk_sys(clk_sys), .pd_out(pd_out),
		.pd_oe_n(pd_oe_n), .strobe_n_out(strobe_n_out),
		.autofd_n_out(autofd_n_out), .pd_in(pd_in), .busy_in(busy_in),
		.ack_n_in(ack_n_in), .got_v(got_v), .got_byte(got_byte));

	// Prints counts and verdict, ends the run
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	// Compare one result
	task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One bus cycle plus a gap; v holds the read answer
	task automatic bus(logic w, logic r, logic [10:0] a, logic [7:0] x);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		rd_chk <= 1'h0;
		@(negedge clk_sys);
		v = reg_rdata;
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(logic [10:0] a, logic [7:0] x);
		bus(1'h1, 1'h0, a, x);
	endtask : wr

	// Checked read: expectation noted before the strobe
	task automatic rd(logic [10:0] a, logic [7:0] e);
		rq.push_back(e);
		rd_chk <= 1'h1;
		bus(1'h0, 1'h1, a, 8'h00);
	endtask : rd

	// Polls the empty bit until it equals e, bounded
	task automatic wait_fifo(logic e);
		for (int i = 0; i < 300; i++) begin
			bus(1'h0, 1'h1, 11'h402, 8'h00);
			if (v[0] === e && (!e || pq.size() == 0))
				return;
		end
		n_errors++;
		$display("Error FIFO state expected %h seen timeout", e);
		give_verdict();
	endtask : wait_fifo

	// Expected byte B from the IRQ and DMA tables
	function automatic logic [7:0] cfg_b(int irq, int dma);
		logic [2:0] q;
		case (irq)
			15: q = 3'h6;
			14: q = 3'h5;
			11: q = 3'h4;
			10: q = 3'h3;
			9: q = 3'h2;
			7: q = 3'h1;
			5: q = 3'h7;
			default: q = 3'h0;
		endcase
		return {2'h0, q, (dma >= 1 && dma <= 3) ? 3'(dma) : 3'h0};
	endfunction : cfg_b

	// Scoreboard: read data and peripheral captures
	always @(posedge clk_sys) begin
		if (chk_q)
			chk("read data", {1'h0, rq.pop_front()}, {1'h0, reg_rdata});
		chk_q <= rd_chk && reg_rd;
		if (got_v)
			chk("peripheral", pq.size() ? pq.pop_front() : 9'h1FF, got_byte);
	end

	// Watchdog
	initial begin
		repeat (50000) @(posedge clk_sys);
		n_errors++;
		$display("Error run length expected end seen timeout");
		give_verdict();
	end

	initial begin
		void'($urandom(32'hB7FE));
		@(posedge clk_sys);
		{fault_n_in, select_in, perror_in} <= 3'($urandom());
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
		rd(11'h402, 8'h01);
		rd(11'h001, {2'h3, perror_in, select_in, fault_n_in, 3'h0});
		chk("open drain", 9'h1, ctrl_open_drain);
		wr(11'h002, 8'h2C);
		chk("data enable", 9'h0, pd_oe_n);
		chk("init", 9'h1, init_n_out);
		chk("select in", 9'h0, selin_n_out);
		rd(11'h002, 8'h0C);
		$display("Test standard mode done");
		wr(11'h402, 8'hE0);
		rd(11'h400, 8'h10);
		rd(11'h401, cfg_b(14, 2));
		wr(11'h402, 8'h60);
		rd(11'h402, 8'hE1);
		chk("open drain", 9'h0, ctrl_open_drain);
		$display("Test configuration mode done");
		wr(11'h402, 8'h20);
		wr(11'h002, 8'h20);
		rd(11'h002, 8'h20);
		chk("data enable", 9'h1, pd_oe_n);
		repeat (2) @(posedge clk_sys);
		rd(11'h000, ~8'hA0);
		$display("Test bidirectional mode done");
		wr(11'h402, 8'hC0);
		for (int i = 0; i < 5; i++) begin
			d[i] = 8'($urandom());
			wr(11'h400, d[i]);
		end
		rd(11'h402, 8'hC2);
		wr(11'h002, 8'h00);
		rd(11'h002, 8'h20);
		for (int i = 0; i < 4; i++)
			rd(11'h400, d[i]);
		rd(11'h402, 8'hC1);
		$display("Test FIFO test mode done");
		wr(11'h402, 8'h20);
		wr(11'h002, 8'h00);
		wr(11'h402, 8'h60);
		for (int i = 0; i < 3; i++) begin
			d[i] = 8'($urandom());
			pq.push_back({i == 1, d[i]});
			wr(i == 1 ? 11'h000 : 11'h400, d[i]);
		end
		wait_fifo(1'h1);
		wr(11'h402, 8'h20);
		chk("strobe", 9'h1, strobe_n_out);
		chk("autofeed", 9'h1, autofd_n_out);
		$display("Test forward transfer done");
		wr(11'h402, 8'h40);
		for (int i = 0; i < 2; i++) begin
			d[i] = 8'($urandom());
			pq.push_back({1'h0, d[i]});
			wr(11'h400, d[i]);
		end
		wait_fifo(1'h1);
		wr(11'h402, 8'h20);
		$display("Test FIFO mode done");
		wr(11'h002, 8'h20);
		wr(11'h402, 8'h60);
		wr(11'h000, 8'h55);
		for (int i = 0; i < 3; i++) begin
			wait_fifo(1'h0);
			rd(11'h400, 8'hA0 + 8'(i));
		end
		wr(11'h402, 8'h20);
		@(negedge clk_sys);
		chk("autofeed", 9'h1, autofd_n_out);
		@(posedge clk_sys);
		wr(11'h002, 8'h00);
		wr(11'h402, 8'h00);
		$display("Test reverse transfer done");
		wr(11'h402, 8'h80);
		chk("epp", 9'h0, epp_active);
		wr(11'h402, 8'h00);
		wr(11'h403, 8'h01);
		wr(11'h402, 8'h80);
		chk("epp", 9'h1, epp_active);
		$display("Test EPP selection done");
		give_verdict();
	end
endmodule : ecp_mode_ctrl_tb
